// ### hdl/rtcal_params.svh
// register offsets, field positions and reset values of the alarm block
// assumes inclusion by bare name from design files only
`ifndef RTCAL_PARAMS_SVH
`define RTCAL_PARAMS_SVH

`define RTCAL_ADDR_MIN_CNT 4'h1
`define RTCAL_ADDR_HOUR_CNT 4'h2
`define RTCAL_ADDR_WEEK_CNT 4'h3
`define RTCAL_ADDR_DATE_CNT 4'h4
`define RTCAL_ADDR_MIN_ALARM 4'h8
`define RTCAL_ADDR_HOUR_ALARM 4'h9
`define RTCAL_ADDR_WD_ALARM 4'ha
`define RTCAL_ADDR_EXT_CTRL 4'hd
`define RTCAL_ADDR_FLAGS 4'he
`define RTCAL_ADDR_INT_CTRL 4'hf

`define RTCAL_CMP_DISABLE_BIT 7
`define RTCAL_WD_SELECT_BIT 6
`define RTCAL_AF_BIT 3
`define RTCAL_AIE_BIT 3
`define RTCAL_RESET_BIT 0

`define RTCAL_MIN_CNT_MASK 8'h7f
`define RTCAL_HOUR_CNT_MASK 8'h3f
`define RTCAL_WEEK_CNT_MASK 8'h7f
`define RTCAL_DATE_CNT_MASK 8'h3f
`define RTCAL_MIN_CMP_MASK 8'h7f
`define RTCAL_HOUR_CMP_MASK 8'h3f
`define RTCAL_WEEK_CMP_MASK 8'h7f
`define RTCAL_DATE_CMP_MASK 8'h3f
`define RTCAL_INT_CTRL_WMASK 8'hfd

`define RTCAL_ALARM_RESET 8'h00
`define RTCAL_EXT_RESET 8'h00
`define RTCAL_INT_CTRL_RESET 8'h00
`define RTCAL_RDATA_RESET 8'h00

`endif

// ### hdl/rtcal_pkg.sv
// types shared by the alarm block modules
// assumes no other package
package rtcal_pkg;
    typedef logic [3:0] rtcal_addr_t;
    typedef logic [7:0] rtcal_byte_t;
endpackage

// ### hdl/rtcal_cmp_if.sv
// alarm settings and time counters carried to the comparator
// assumes one driver, the top module
`timescale 1ns/1ps
interface rtcal_cmp_if;
    rtcal_pkg::rtcal_byte_t min_alarm;
    rtcal_pkg::rtcal_byte_t hour_alarm;
    rtcal_pkg::rtcal_byte_t wd_alarm;
    rtcal_pkg::rtcal_byte_t min_cnt;
    rtcal_pkg::rtcal_byte_t hour_cnt;
    rtcal_pkg::rtcal_byte_t week_cnt;
    rtcal_pkg::rtcal_byte_t date_cnt;
    logic weekday_date_select;
    logic hit;
    modport cmp (
        input min_alarm,
        input hour_alarm,
        input wd_alarm,
        input min_cnt,
        input hour_cnt,
        input week_cnt,
        input date_cnt,
        input weekday_date_select,
        output hit
    );
    modport src (
        output min_alarm,
        output hour_alarm,
        output wd_alarm,
        output min_cnt,
        output hour_cnt,
        output week_cnt,
        output date_cnt,
        output weekday_date_select,
        input hit
    );
endinterface

// ### hdl/rtcal_match.sv
// combinational alarm comparator
// assumes counters hold the freshly entered time
`timescale 1ns/1ps
`include "rtcal_params.svh"
module rtcal_match (
    rtcal_cmp_if.cmp c
);
    logic min_ok;
    logic hour_ok;
    logic week_ok;
    logic date_ok;
    logic wd_ok;

    always_comb begin
        // masked bcd digits, bit 6 of hour and date is storage only
        min_ok = c.min_alarm[`RTCAL_CMP_DISABLE_BIT]
            || ((c.min_alarm & `RTCAL_MIN_CMP_MASK) == (c.min_cnt & `RTCAL_MIN_CMP_MASK));
        hour_ok = c.hour_alarm[`RTCAL_CMP_DISABLE_BIT]
            || ((c.hour_alarm & `RTCAL_HOUR_CMP_MASK) == (c.hour_cnt & `RTCAL_HOUR_CMP_MASK));
        // any selected weekday matches
        week_ok = (c.wd_alarm & c.week_cnt & `RTCAL_WEEK_CMP_MASK) != 8'h00;
        date_ok = (c.wd_alarm & `RTCAL_DATE_CMP_MASK) == (c.date_cnt & `RTCAL_DATE_CMP_MASK);
        wd_ok = c.wd_alarm[`RTCAL_CMP_DISABLE_BIT]
            || (c.weekday_date_select ? date_ok : week_ok);
        c.hit = min_ok && hour_ok && wd_ok;
    end
endmodule

// ### hdl/rtcal_sticky.sv
// sticky flag, set beats clear
// assumes set and clear are one-cycle pulses
`timescale 1ns/1ps
module rtcal_sticky (
    input wire logic clk,
    input wire logic rst,
    input wire logic set,
    input wire logic clr,
    output logic q
);
    logic flag_q;
    logic flag_d;

    always_comb begin
        flag_d = flag_q;
        if (clr) begin
            flag_d = 1'b0;
        end
        if (set) begin
            flag_d = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            flag_q <= 1'b0;
        end else begin
            flag_q <= flag_d;
        end
    end

    assign q = flag_q;
endmodule

// ### hdl/rtcal_top.sv
// alarm interrupt block: alarm registers, comparison, flag and interrupt pin
// assumes counters and minute_tick come from the clock counter in this clock domain
`timescale 1ns/1ps
`include "rtcal_params.svh"

module rtcal_top (
    input wire logic clk,
    input wire logic rst,
    input wire rtcal_pkg::rtcal_addr_t reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire rtcal_pkg::rtcal_byte_t reg_wdata,
    output rtcal_pkg::rtcal_byte_t reg_rdata,
    input wire rtcal_pkg::rtcal_byte_t min_cnt,
    input wire rtcal_pkg::rtcal_byte_t hour_cnt,
    input wire rtcal_pkg::rtcal_byte_t week_cnt,
    input wire rtcal_pkg::rtcal_byte_t date_cnt,
    input wire logic minute_tick,
    input wire logic other_int_req,
    output logic alarm_flag,
    output logic int_o,
    output logic int_oe
);
    rtcal_pkg::rtcal_byte_t min_alarm_q;
    rtcal_pkg::rtcal_byte_t min_alarm_d;
    rtcal_pkg::rtcal_byte_t hour_alarm_q;
    rtcal_pkg::rtcal_byte_t hour_alarm_d;
    rtcal_pkg::rtcal_byte_t wd_alarm_q;
    rtcal_pkg::rtcal_byte_t wd_alarm_d;
    rtcal_pkg::rtcal_byte_t ext_ctrl_q;
    rtcal_pkg::rtcal_byte_t ext_ctrl_d;
    rtcal_pkg::rtcal_byte_t int_ctrl_q;
    rtcal_pkg::rtcal_byte_t int_ctrl_d;
    rtcal_pkg::rtcal_byte_t rdata_q;
    rtcal_pkg::rtcal_byte_t rdata_d;
    rtcal_pkg::rtcal_byte_t rd_mux;

    logic wr_min_alarm;
    logic wr_hour_alarm;
    logic wr_wd_alarm;
    logic wr_ext_ctrl;
    logic wr_flags;
    logic wr_int_ctrl;

    logic alarm_hit;
    logic alarm_event;
    logic af_clear;
    logic af_q;
    logic alarm_irq_enable;
    logic reset_hold;
    logic alarm_drive;

    rtcal_cmp_if cmp_bus ();

    // address decode for writes
    always_comb begin
        wr_min_alarm = reg_wr && (reg_addr == `RTCAL_ADDR_MIN_ALARM);
        wr_hour_alarm = reg_wr && (reg_addr == `RTCAL_ADDR_HOUR_ALARM);
        wr_wd_alarm = reg_wr && (reg_addr == `RTCAL_ADDR_WD_ALARM);
        wr_ext_ctrl = reg_wr && (reg_addr == `RTCAL_ADDR_EXT_CTRL);
        wr_flags = reg_wr && (reg_addr == `RTCAL_ADDR_FLAGS);
        wr_int_ctrl = reg_wr && (reg_addr == `RTCAL_ADDR_INT_CTRL);
    end

    // alarm setting registers, all eight bits stored
    always_comb begin
        min_alarm_d = min_alarm_q;
        hour_alarm_d = hour_alarm_q;
        wd_alarm_d = wd_alarm_q;
        if (wr_min_alarm) begin
            min_alarm_d = reg_wdata;
        end
        if (wr_hour_alarm) begin
            hour_alarm_d = reg_wdata;
        end
        if (wr_wd_alarm) begin
            wd_alarm_d = reg_wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            min_alarm_q <= `RTCAL_ALARM_RESET;
            hour_alarm_q <= `RTCAL_ALARM_RESET;
            wd_alarm_q <= `RTCAL_ALARM_RESET;
        end else begin
            min_alarm_q <= min_alarm_d;
            hour_alarm_q <= hour_alarm_d;
            wd_alarm_q <= wd_alarm_d;
        end
    end

    // extension and interrupt control registers
    always_comb begin
        ext_ctrl_d = ext_ctrl_q;
        int_ctrl_d = int_ctrl_q;
        if (wr_ext_ctrl) begin
            ext_ctrl_d = reg_wdata;
        end
        if (wr_int_ctrl) begin
            int_ctrl_d = reg_wdata & `RTCAL_INT_CTRL_WMASK;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ext_ctrl_q <= `RTCAL_EXT_RESET;
            int_ctrl_q <= `RTCAL_INT_CTRL_RESET;
        end else begin
            ext_ctrl_q <= ext_ctrl_d;
            int_ctrl_q <= int_ctrl_d;
        end
    end

    assign alarm_irq_enable = int_ctrl_q[`RTCAL_AIE_BIT];
    assign reset_hold = int_ctrl_q[`RTCAL_RESET_BIT];

    // comparator hookup
    assign cmp_bus.min_alarm = min_alarm_q;
    assign cmp_bus.hour_alarm = hour_alarm_q;
    assign cmp_bus.wd_alarm = wd_alarm_q;
    assign cmp_bus.min_cnt = min_cnt;
    assign cmp_bus.hour_cnt = hour_cnt;
    assign cmp_bus.week_cnt = week_cnt;
    assign cmp_bus.date_cnt = date_cnt;
    assign cmp_bus.weekday_date_select = ext_ctrl_q[`RTCAL_WD_SELECT_BIT];
    assign alarm_hit = cmp_bus.hit;

    rtcal_match u_match (
        .c(cmp_bus.cmp)
    );

    // event only on the tick that enters a new minute
    always_comb begin
        alarm_event = minute_tick && alarm_hit && !reset_hold;
    end

    // only a written zero clears the flag
    always_comb begin
        af_clear = wr_flags && !reg_wdata[`RTCAL_AF_BIT];
    end

    rtcal_sticky u_alarm_flag (
        .clk(clk),
        .rst(rst),
        .set(alarm_event),
        .clr(af_clear),
        .q(af_q)
    );

    // open drain pin, low while flag and enable both hold
    always_comb begin
        alarm_drive = af_q && alarm_irq_enable;
    end

    assign int_o = 1'b0;
    assign int_oe = alarm_drive || other_int_req;
    assign alarm_flag = af_q;

    // read mux with fixed zero bits masked
    always_comb begin
        rd_mux = 8'h00;
        unique case (reg_addr)
            `RTCAL_ADDR_MIN_CNT: begin
                rd_mux = min_cnt & `RTCAL_MIN_CNT_MASK;
            end
            `RTCAL_ADDR_HOUR_CNT: begin
                rd_mux = hour_cnt & `RTCAL_HOUR_CNT_MASK;
            end
            `RTCAL_ADDR_WEEK_CNT: begin
                rd_mux = week_cnt & `RTCAL_WEEK_CNT_MASK;
            end
            `RTCAL_ADDR_DATE_CNT: begin
                rd_mux = date_cnt & `RTCAL_DATE_CNT_MASK;
            end
            `RTCAL_ADDR_MIN_ALARM: begin
                rd_mux = min_alarm_q;
            end
            `RTCAL_ADDR_HOUR_ALARM: begin
                rd_mux = hour_alarm_q;
            end
            `RTCAL_ADDR_WD_ALARM: begin
                rd_mux = wd_alarm_q;
            end
            `RTCAL_ADDR_EXT_CTRL: begin
                rd_mux = ext_ctrl_q;
            end
            `RTCAL_ADDR_FLAGS: begin
                rd_mux[`RTCAL_AF_BIT] = af_q;
            end
            `RTCAL_ADDR_INT_CTRL: begin
                rd_mux = int_ctrl_q;
            end
            default: begin
                rd_mux = 8'h00;
            end
        endcase
    end

    // read data registered on the read strobe
    always_comb begin
        rdata_d = rdata_q;
        if (reg_rd) begin
            rdata_d = rd_mux;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_q <= `RTCAL_RDATA_RESET;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;
endmodule

// ### testbench/rtcal_host.sv
// host side of the shared interrupt line
// assumes a pull-up on the line and one open-drain driver
`timescale 1ns/1ps
module rtcal_host (
    input wire logic int_o,
    input wire logic int_oe,
    output logic int_n
);
    // pulled high unless some driver sinks it
    assign int_n = int_oe ? int_o : 1'b1;
endmodule

// ### testbench/rtcal_checker.sv
// port assertions for the alarm block
// assumes binding into rtcal_top
`timescale 1ns/1ps
module rtcal_checker (
    input wire logic clk,
    input wire logic rst,
    input wire rtcal_pkg::rtcal_addr_t reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire rtcal_pkg::rtcal_byte_t reg_wdata,
    input wire rtcal_pkg::rtcal_byte_t reg_rdata,
    input wire logic minute_tick,
    input wire logic other_int_req,
    input wire logic alarm_flag,
    input wire logic int_o,
    input wire logic int_oe
);
    logic aie_q;
    logic rbit_q;
    logic [2:0] dis_q;
    logic clr_w;
    assign clr_w = reg_wr && reg_addr == 4'he && !reg_wdata[3];
    // shadow of enable, reset bit and compare disables
    always_ff @(posedge clk) begin
        if (rst) begin
            aie_q <= 1'b0;
            rbit_q <= 1'b0;
            dis_q <= 3'h0;
        end else if (reg_wr) begin
            if (reg_addr == 4'hf) begin
                aie_q <= reg_wdata[3];
                rbit_q <= reg_wdata[0];
            end
            if (reg_addr[3:2] == 2'b10 && reg_addr[1:0] != 2'b11) begin
                dis_q[reg_addr[1:0]] <= reg_wdata[7];
            end
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_pin_value_low: assert property (int_o == 1'b0) else $error("pin value not low");
    a_oe_follows_cause: assert property (int_oe == (other_int_req | (alarm_flag & aie_q)))
        else $error("pin enable wrong");
    a_flag_held: assert property (alarm_flag && !clr_w |=> alarm_flag) else $error("flag lost");
    a_flag_cleared: assert property (alarm_flag && clr_w && !minute_tick |=> !alarm_flag)
        else $error("flag not cleared");
    a_no_tick_set: assert property (!alarm_flag && !minute_tick |=> !alarm_flag)
        else $error("flag set without tick");
    a_reset_blocks: assert property (rbit_q && !alarm_flag |=> !alarm_flag) else $error("event in reset");
    a_every_minute: assert property (minute_tick && &dis_q && !rbit_q |=> alarm_flag)
        else $error("no event with all disabled");
    a_flag_fixed_zero: assert property (reg_rd && reg_addr == 4'he |=> reg_rdata[7:4] == 4'h0
        && reg_rdata[2:0] == 3'h0) else $error("fixed bits not zero");
    a_rise_has_tick: assert property ($rose(alarm_flag) |-> $past(minute_tick))
        else $error("flag rose off tick");
endmodule
bind rtcal_top rtcal_checker chk (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .minute_tick(minute_tick),
    .other_int_req(other_int_req), .alarm_flag(alarm_flag), .int_o(int_o), .int_oe(int_oe));

// ### testbench/tb_top.sv
// self-checking bench for the alarm block
// assumes rtcal_top, its package and the host model are compiled first
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((e) !== (g)) begin mismatches++; \
    $display("wrong value %s expected %h seen %h", n, e, g); end end
module tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic [7:0] min_cnt = 8'hff;
    logic [7:0] hour_cnt = 8'h00;
    logic [7:0] week_cnt = 8'h00;
    logic [7:0] date_cnt = 8'h00;
    logic minute_tick = 1'b0;
    logic other_int_req = 1'b0;
    logic alarm_flag;
    logic int_o;
    logic int_oe;
    logic int_n;
    int mismatches = 0;
    int tests_run = 0;
    always #2 clk = ~clk;
    rtcal_top dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .min_cnt(min_cnt), .hour_cnt(hour_cnt),
        .week_cnt(week_cnt), .date_cnt(date_cnt), .minute_tick(minute_tick),
        .other_int_req(other_int_req), .alarm_flag(alarm_flag), .int_o(int_o), .int_oe(int_oe));
    rtcal_host host (.int_o(int_o), .int_oe(int_oe), .int_n(int_n));
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        `CHK("reg_rdata", e, reg_rdata)
    endtask
    task automatic tick(input logic [7:0] m, input logic [7:0] h, input logic [7:0] w, input logic [7:0] d);
        @(posedge clk);
        min_cnt <= m;
        hour_cnt <= h;
        week_cnt <= w;
        date_cnt <= d;
        minute_tick <= 1'b1;
        @(posedge clk);
        minute_tick <= 1'b0;
        #1;
    endtask
    task automatic pin(input logic f, input logic n);
        `CHK("alarm_flag", f, alarm_flag)
        `CHK("int_n", n, int_n)
    endtask
    task automatic t_regs();
        wr(4'h8, 8'hff);
        wr(4'h9, 8'hff);
        wr(4'ha, 8'hff);
        rd(4'h8, 8'hff);
        rd(4'h9, 8'hff);
        rd(4'ha, 8'hff);
        wr(4'he, 8'hff);
        rd(4'he, 8'h00);
        wr(4'hf, 8'hf7);
        rd(4'hf, 8'hf5);
        wr(4'hf, 8'h00);
        wr(4'h1, 8'h00);
        rd(4'h1, 8'h7f);
        rd(4'h5, 8'h00);
        $display("regs done");
    endtask
    task automatic t_week();
        wr(4'hf, 8'h00);
        wr(4'hd, 8'h00);
        wr(4'h8, 8'h30);
        wr(4'h9, 8'h07);
        wr(4'ha, 8'h3e);
        wr(4'hf, 8'h08);
        tick(8'h30, 8'h07, 8'h01, 8'h01);
        pin(1'b0, 1'b1);
        tick(8'h30, 8'h07, 8'h04, 8'h01);
        pin(1'b1, 1'b0);
        wr(4'he, 8'h08);
        pin(1'b1, 1'b0);
        wr(4'hf, 8'h00);
        pin(1'b1, 1'b1);
        wr(4'hf, 8'h08);
        pin(1'b1, 1'b0);
        wr(4'he, 8'h00);
        pin(1'b0, 1'b1);
        wr(4'hf, 8'h00);
        wr(4'h8, 8'h30);
        wr(4'hf, 8'h08);
        repeat (4) @(posedge clk);
        #1;
        pin(1'b0, 1'b1);
        $display("week done");
    endtask
    task automatic t_date();
        wr(4'hf, 8'h00);
        wr(4'hd, 8'h40);
        wr(4'h9, 8'h80);
        wr(4'ha, 8'h55);
        wr(4'hf, 8'h08);
        tick(8'h30, 8'h12, 8'h7f, 8'h14);
        pin(1'b0, 1'b1);
        tick(8'h30, 8'h03, 8'h00, 8'h15);
        pin(1'b1, 1'b0);
        wr(4'he, 8'h00);
        $display("date done");
    endtask
    task automatic t_alldis();
        wr(4'hf, 8'h00);
        wr(4'h8, 8'h80);
        wr(4'ha, 8'h80);
        wr(4'hf, 8'h01);
        tick(8'h00, 8'h00, 8'h00, 8'h00);
        pin(1'b0, 1'b1);
        wr(4'hf, 8'h00);
        tick(8'h01, 8'h00, 8'h00, 8'h00);
        pin(1'b1, 1'b1);
        @(posedge clk);
        other_int_req <= 1'b1;
        @(posedge clk);
        #1;
        pin(1'b1, 1'b0);
        @(posedge clk);
        other_int_req <= 1'b0;
        @(posedge clk);
        #1;
        pin(1'b1, 1'b1);
        wr(4'he, 8'h00);
        $display("all disabled done");
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge clk);
        mismatches++;
        $display("run stalled");
        tally_and_finish();
    end
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_week();
        t_date();
        t_alldis();
        tally_and_finish();
    end
endmodule
